/* ser_status.sv */
`timescale 1ns/100ps
// How it works
// - clear-status empties output queue, zeroes events
// - masked flags summarize into status bit 5
// - event mask is eight bits, read back
// - flags read returns value then clears
// - completion command sets flag bit 0 when idle
// - completion query queues ASCII 1 when idle
// - completion query leaves flag bit 0
// - commands run in order, wait is no-op
// - error read pops oldest queued entry
// - preset loads operation, questionable groups
// - operation enable mask writable and readable
// - operation event and condition readable
// - questionable enable mask writable and readable
// - questionable event readable
// - reset restores ohm autorange, keeps stored sets
// - save copies settings into chosen slot
// - recall reloads settings from chosen slot
// - identity query returns identity fields
// - compare flag settable and readable
// - limits, nominal stored; compare result readable
// - percentage flag settable and readable
// - relative flag and reference stored
// - service mask bit 6 reads zero
// - status byte readable as eight bits
module ser_status import ser_pkg::*; #(
  parameter int SLOTS = 20,             // stored setting sets
  parameter int QDEPTH = 4,             // queue depth, power of two
  parameter logic [31:0] IDENT = 32'h5A5A0100  // identity word, arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [4:0] i_addr,        // register index
  input wire logic [31:0] i_wdata,      // write data
  input wire logic i_wr,                // write strobe
  input wire logic i_rd,                // read strobe
  input wire logic i_busy,              // pending operations running
  input wire logic [7:0] i_std_evt,     // standard event pulses
  input wire logic [15:0] i_oper_cond,  // operation condition levels
  input wire logic [15:0] i_ques_cond,  // questionable condition levels
  input wire logic i_err_push,          // error entry pulse
  input wire logic [7:0] i_err_code,    // error entry code
  input wire logic [31:0] i_reading,    // present measured value
  output logic [31:0] o_rdata,          // read data, cycle after strobe
  output logic [7:0] o_status_byte,     // status_summary_byte
  output logic [1:0] o_function,        // measuring function
  output logic o_auto_range             // automatic ranging on
);
  // software reaches every register through one indexed port; reads answer
  // one cycle after the strobe and never stall the host
  // pointer width carries one extra wrap bit to tell full from empty
  localparam int QW = $clog2(QDEPTH);
  // slot index width for the setting store
  localparam int SW = $clog2(SLOTS);

  // queue pointer increment
  // wraps naturally because the wrap bit is the top bit
  function automatic logic [QW:0] ser_inc(input logic [QW:0] p);
    ser_inc = p + 1'b1;
  endfunction

  // state
  // all of it resets to fixed values except queue storage and stored sets
  logic [7:0] event_enable_mask, standard_event_flags, service_request_mask;
  logic [15:0] oper_evt, oper_mask, ques_evt, ques_mask;
  logic [7:0] outq [QDEPTH];
  logic [7:0] errq [QDEPTH];
  logic [QW:0] oq_wp, oq_rp, eq_wp, eq_rp;
  logic opc_pend, opcq_pend;
  ser_set_t cur;
  ser_set_t store [SLOTS];
  logic [SW-1:0] slot;
  logic [1:0] fail;
  logic [15:0] oper_q, ques_q;            // previous conditions
  ser_state_t state;
  // next values
  // all are computed by the one combinational process below
  logic [7:0] next_eem, next_sef, next_srm;
  logic [15:0] next_oe, next_om, next_qe, next_qm;
  logic [QW:0] next_oq_wp, next_oq_rp, next_eq_wp, next_eq_rp;
  logic next_opc, next_opcq;
  ser_set_t next_cur;
  logic [SW-1:0] next_slot;
  logic [31:0] next_rdata;
  logic [7:0] next_stb;
  logic [1:0] next_fail;
  ser_state_t next_state;
  logic cmd, oq_full, eq_full, oq_empty, eq_empty, oq_push, event_summary_bit;
  logic [7:0] cmd_code;

  // a command is a write to index zero, code in the low byte
  assign cmd = i_wr && (i_addr == SER_A_CMD);
  assign cmd_code = i_wdata[7:0];
  // queue state from pointers that carry a wrap bit
  assign oq_empty = (oq_wp == oq_rp);
  assign eq_empty = (eq_wp == eq_rp);
  assign oq_full = (oq_wp[QW-1:0] == oq_rp[QW-1:0]) && (oq_wp[QW] != oq_rp[QW]);
  assign eq_full = (eq_wp[QW-1:0] == eq_rp[QW-1:0]) && (eq_wp[QW] != eq_rp[QW]);
  // summary bit straight from flags and mask
  assign event_summary_bit = |(standard_event_flags & event_enable_mask);
  // completion query answers once nothing is pending and there is room
  assign oq_push = opcq_pend && !i_busy && !oq_full;

  // next state of all status registers
  always_comb begin
    // hold every register unless something below changes it
    next_eem = event_enable_mask;
    next_srm = service_request_mask;
    next_om = oper_mask;
    next_qm = ques_mask;
    next_cur = cur;
    next_slot = slot;
    next_opc = opc_pend;
    next_opcq = opcq_pend;
    next_oq_wp = oq_push ? ser_inc(oq_wp) : oq_wp;
    next_oq_rp = oq_rp;
    next_eq_wp = (i_err_push && !eq_full) ? ser_inc(eq_wp) : eq_wp;
    next_eq_rp = eq_rp;
    next_state = (opc_pend || opcq_pend) ? SER_WAIT : SER_IDLE;
    // event latching; sets below win over clears
    next_sef = standard_event_flags;
    next_oe = oper_evt;
    next_qe = ques_evt;
    // register writes
    // only one strobe is high at a time, so writes and reads never meet
    if (i_wr) begin
      case (i_addr)
        SER_A_ESE: next_eem = i_wdata[7:0];
        SER_A_SRE: next_srm = i_wdata[7:0] & SER_RQS_MASK;
        SER_A_OPM: next_om = i_wdata[15:0];
        SER_A_QUM: next_qm = i_wdata[15:0];
        SER_A_MODE: next_cur.mode = i_wdata[3:0];
        SER_A_LOW: next_cur.low = i_wdata;
        SER_A_UPP: next_cur.upp = i_wdata;
        SER_A_NOM: next_cur.nom = i_wdata;
        SER_A_REF: next_cur.rref = i_wdata;
        SER_A_SLOT: next_slot = i_wdata[SW-1:0];
        default: ;
      endcase
    end
    // commands, taken one at a time in arrival order
    if (cmd) begin
      case (cmd_code)
        SER_C_CLS: begin
          next_sef = SER_ZERO8;
          next_oe = SER_PRESET;
          next_qe = SER_PRESET;
          // drop queued answers by catching the read pointer up
          next_oq_rp = oq_wp;
          // a query still waiting is cancelled too
          next_opcq = 1'b0;
        end
        SER_C_OPC: next_opc = 1'b1;
        SER_C_OPCQ: next_opcq = 1'b1;
        SER_C_WAI: ;
        SER_C_PRES: begin
          // masks and events to their preset values
          next_om = SER_PRESET;
          next_qm = SER_PRESET;
          next_oe = SER_PRESET;
          next_qe = SER_PRESET;
        end
        SER_C_RST: begin
          // limits and stored sets are left alone
          next_cur.mode = '0;
          next_cur.mode[SER_M_AUTO] = 1'b1;
        end
        SER_C_RCL: next_cur = store[slot];
        default: ;
      endcase
    end
    // reads with side effects
    if (i_rd) begin
      case (i_addr)
        SER_A_ESR: next_sef = SER_ZERO8;
        SER_A_OUTQ: if (!oq_empty) next_oq_rp = ser_inc(oq_rp);
        SER_A_ERRQ: if (!eq_empty) next_eq_rp = ser_inc(eq_rp);
        default: ;
      endcase
    end
    // completion reporting when nothing is pending
    if (opc_pend && !i_busy) begin
      next_sef[SER_B_OPCB] = 1'b1;
      next_opc = 1'b0;
    end
    if (oq_push) next_opcq = 1'b0;
    // event sets last so they win
    next_sef = next_sef | i_std_evt;
    // conditions set their event bit on a rising edge only
    next_oe = next_oe | (i_oper_cond & ~oper_q);
    next_qe = next_qe | (i_ques_cond & ~ques_q);
    // compare result
    // unsigned compare of the present reading against both limits
    if (i_reading < cur.low) next_fail = SER_LOW;
    else if (i_reading > cur.upp) next_fail = SER_HIGH;
    else next_fail = SER_PASS;
    // status byte
    next_stb = SER_ZERO8;
    next_stb[SER_B_EVSUM] = |(next_sef & next_eem);
    next_stb[SER_B_MAV] = (next_oq_wp != next_oq_rp);
    next_stb[SER_B_EAV] = (next_eq_wp != next_eq_rp);
    next_stb[SER_B_QSB] = |(next_qe & next_qm);
    next_stb[SER_B_OSB] = |(next_oe & next_om);
    // bit 6 requests service when any enabled bit is set
    next_stb[SER_B_RQS] = |(next_stb & next_srm);
    // read mux
    // empty queues read as zero and keep their pointers
    next_rdata = '0;
    if (i_rd) begin
      case (i_addr)
        SER_A_ESE: next_rdata = {24'h000000, event_enable_mask};
        SER_A_ESR: next_rdata = {24'h000000, standard_event_flags};
        SER_A_SRE: next_rdata = {24'h000000, service_request_mask};
        SER_A_STB: next_rdata = {24'h000000, o_status_byte};
        SER_A_OPC: next_rdata = {16'h0000, i_oper_cond};
        SER_A_OPE: next_rdata = {16'h0000, oper_evt};
        SER_A_OPM: next_rdata = {16'h0000, oper_mask};
        SER_A_QUC: next_rdata = {16'h0000, i_ques_cond};
        SER_A_QUE: next_rdata = {16'h0000, ques_evt};
        SER_A_QUM: next_rdata = {16'h0000, ques_mask};
        SER_A_OUTQ: next_rdata = {24'h000000, oq_empty ? SER_ZERO8 : outq[oq_rp[QW-1:0]]};
        SER_A_ERRQ: next_rdata = {24'h000000, eq_empty ? SER_ZERO8 : errq[eq_rp[QW-1:0]]};
        SER_A_MODE: next_rdata = {28'h0000000, cur.mode};
        SER_A_LOW: next_rdata = cur.low;
        SER_A_UPP: next_rdata = cur.upp;
        SER_A_NOM: next_rdata = cur.nom;
        SER_A_REF: next_rdata = cur.rref;
        SER_A_FAIL: next_rdata = {30'h0, fail};
        SER_A_SLOT: next_rdata = 32'(slot);
        SER_A_IDN: next_rdata = IDENT;
        default: next_rdata = '0;
      endcase
    end
  end

  // register all next values
  // outputs come straight from these flip-flops
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_enable_mask <= SER_ZERO8;
      standard_event_flags <= SER_ZERO8;
      service_request_mask <= SER_ZERO8;
      oper_evt <= SER_PRESET;
      oper_mask <= SER_PRESET;
      ques_evt <= SER_PRESET;
      ques_mask <= SER_PRESET;
      oq_wp <= '0;
      oq_rp <= '0;
      eq_wp <= '0;
      eq_rp <= '0;
      opc_pend <= 1'b0;
      opcq_pend <= 1'b0;
      cur <= '0;
      slot <= '0;
      fail <= SER_PASS;
      oper_q <= SER_PRESET;
      ques_q <= SER_PRESET;
      state <= SER_IDLE;
      o_rdata <= '0;
      o_status_byte <= SER_ZERO8;
      o_function <= SER_F_OHM;
      o_auto_range <= 1'b0;
    end else begin
      event_enable_mask <= next_eem;
      standard_event_flags <= next_sef;
      service_request_mask <= next_srm;
      oper_evt <= next_oe;
      oper_mask <= next_om;
      ques_evt <= next_qe;
      ques_mask <= next_qm;
      oq_wp <= next_oq_wp;
      oq_rp <= next_oq_rp;
      eq_wp <= next_eq_wp;
      eq_rp <= next_eq_rp;
      opc_pend <= next_opc;
      opcq_pend <= next_opcq;
      cur <= next_cur;
      slot <= next_slot;
      fail <= next_fail;
      oper_q <= i_oper_cond;
      ques_q <= i_ques_cond;
      state <= next_state;
      o_rdata <= next_rdata;
      o_status_byte <= next_stb;
      o_function <= SER_F_OHM;
      o_auto_range <= next_cur.mode[SER_M_AUTO];
    end
  end

  // queue storage and setting store, no reset needed
  // queue slots are written at the write pointer; pops only move pointers
  // slot values at or above SLOTS are not guarded; software keeps below
  always_ff @(posedge i_core_clk) begin
    if (oq_push) outq[oq_wp[QW-1:0]] <= SER_ASCII_1;
    if (i_err_push && !eq_full) errq[eq_wp[QW-1:0]] <= i_err_code;
    if (cmd && cmd_code == SER_C_SAV) store[slot] <= cur;
  end

  // checks
  // a flags read with no event arriving leaves the register empty
  chk_esr_clear: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == SER_A_ESR && i_std_evt == 8'h00 && !(opc_pend && !i_busy))
    |=> standard_event_flags == 8'h00) else $error("flags not cleared after read");
  // a flags read returns the value held before the read
  chk_esr_data: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_rd && i_addr == SER_A_ESR) |=> o_rdata[7:0] == $past(standard_event_flags))
    else $error("flags read wrong");
  // clear-status empties flags and output queue when nothing sets them again
  chk_cls_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cmd && cmd_code == SER_C_CLS && i_std_evt == 8'h00 && !oq_push
    && !(opc_pend && !i_busy)) |=> standard_event_flags == 8'h00 && oq_empty)
    else $error("clear status incomplete");
  // the summary bit on the pins always matches the masked flags
  chk_esb_sum: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_status_byte[SER_B_EVSUM] == event_summary_bit) else $error("summary bit wrong");
  // the completion command sets bit 0 as soon as nothing is pending
  chk_opc_set: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (opc_pend && !i_busy) |=> standard_event_flags[SER_B_OPCB])
    else $error("completion flag missing");
  // the completion query never touches bit 0 by itself
  chk_opcq_keep: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cmd && cmd_code == SER_C_OPCQ && !opc_pend && !standard_event_flags[SER_B_OPCB]
    && i_std_evt == 8'h00) |=> !standard_event_flags[SER_B_OPCB])
    else $error("query set flag");
  // the request bit of the service mask can never be stored
  chk_sre_bit6: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !service_request_mask[SER_B_RQS]) else $error("mask bit 6 set");
  // an event mask write is held from the next cycle on
  chk_ese_back: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_wr && i_addr == SER_A_ESE) |=> event_enable_mask == $past(i_wdata[7:0]))
    else $error("event mask not stored");
  // the reset command turns automatic ranging on at the next edge
  chk_rst_auto: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (cmd && cmd_code == SER_C_RST) |=> o_auto_range) else $error("reset no autorange");
  // main scenarios
  cov_wait: cover property (@(posedge i_core_clk) state == SER_WAIT && !i_busy);
  cov_opcq: cover property (@(posedge i_core_clk) oq_push);
  cov_esr: cover property (@(posedge i_core_clk) i_rd && i_addr == SER_A_ESR
    && standard_event_flags != 8'h00);
  cov_err: cover property (@(posedge i_core_clk) i_rd && i_addr == SER_A_ERRQ && !eq_empty);
endmodule

/* ser_pkg.sv */
package ser_pkg;
  // register indices on the command port
  localparam logic [4:0] SER_A_CMD = 5'h00;   // write: command strobes
  localparam logic [4:0] SER_A_ESE = 5'h01;   // event_enable_mask
  localparam logic [4:0] SER_A_ESR = 5'h02;   // standard_event_flags, read clears
  localparam logic [4:0] SER_A_SRE = 5'h03;   // service_request_mask
  localparam logic [4:0] SER_A_STB = 5'h04;   // status_summary_byte
  localparam logic [4:0] SER_A_OPC = 5'h05;   // operation condition (ro)
  localparam logic [4:0] SER_A_OPE = 5'h06;   // operation event (ro)
  localparam logic [4:0] SER_A_OPM = 5'h07;   // operation enable mask
  localparam logic [4:0] SER_A_QUC = 5'h08;   // questionable condition (ro)
  localparam logic [4:0] SER_A_QUE = 5'h09;   // questionable event (ro)
  localparam logic [4:0] SER_A_QUM = 5'h0A;   // questionable enable mask
  localparam logic [4:0] SER_A_OUTQ = 5'h0B;  // output queue pop (ro)
  localparam logic [4:0] SER_A_ERRQ = 5'h0C;  // error queue pop (ro)
  localparam logic [4:0] SER_A_MODE = 5'h0D;  // mode flags
  localparam logic [4:0] SER_A_LOW = 5'h0E;   // lower limit
  localparam logic [4:0] SER_A_UPP = 5'h0F;   // upper limit
  localparam logic [4:0] SER_A_NOM = 5'h10;   // nominal value
  localparam logic [4:0] SER_A_REF = 5'h11;   // relative reference
  localparam logic [4:0] SER_A_FAIL = 5'h12;  // compare result (ro)
  localparam logic [4:0] SER_A_SLOT = 5'h13;  // save/recall slot index
  localparam logic [4:0] SER_A_IDN = 5'h14;   // identity word (ro)
  // command codes written to SER_A_CMD
  localparam logic [7:0] SER_C_CLS = 8'h01;
  localparam logic [7:0] SER_C_OPC = 8'h02;
  localparam logic [7:0] SER_C_OPCQ = 8'h03;
  localparam logic [7:0] SER_C_WAI = 8'h04;
  localparam logic [7:0] SER_C_PRES = 8'h05;
  localparam logic [7:0] SER_C_RST = 8'h06;
  localparam logic [7:0] SER_C_SAV = 8'h07;
  localparam logic [7:0] SER_C_RCL = 8'h08;
  // bit positions
  localparam int SER_B_EVSUM = 5;    // event summary bit in status byte
  localparam int SER_B_MAV = 4;      // message available
  localparam int SER_B_EAV = 2;      // error queue not empty
  localparam int SER_B_QSB = 3;      // questionable summary
  localparam int SER_B_OSB = 7;      // operation summary
  localparam int SER_B_RQS = 6;      // request-service bit, mask reads zero
  localparam int SER_B_OPCB = 0;     // operation complete flag
  // mode flag positions
  localparam int SER_M_CMP = 0;
  localparam int SER_M_PCT = 1;
  localparam int SER_M_RELATIVE = 2;
  localparam int SER_M_AUTO = 3;
  localparam logic [1:0] SER_F_OHM = 2'h0;  // ohm function code
  localparam logic [7:0] SER_ASCII_1 = 8'h31;
  localparam logic [15:0] SER_PRESET = 16'h0000;  // preset masks and events
  localparam logic [7:0] SER_ZERO8 = 8'h00;
  localparam logic [7:0] SER_RQS_MASK = 8'hBF;
  localparam logic [1:0] SER_PASS = 2'h1;
  localparam logic [1:0] SER_LOW = 2'h0;
  localparam logic [1:0] SER_HIGH = 2'h2;
  // stored setting set
  typedef struct packed {
    logic [31:0] low;
    logic [31:0] upp;
    logic [31:0] nom;
    logic [31:0] rref;
    logic [3:0] mode;
  } ser_set_t;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_WAIT = 2'b01
  } ser_state_t;
endpackage

/* ser_host.sv */
`timescale 1ns/100ps
// host controller model: issues register writes and reads on the command port
module ser_host (
  input wire logic i_core_clk,
  input wire logic [31:0] i_rdata,  // read data from the block
  output logic [4:0] o_addr,        // register index
  output logic [31:0] o_wdata,      // write data
  output logic o_wr,                // write strobe
  output logic o_rd                 // read strobe
);
  // idle lines carry the inverse of the last value so stray sampling shows up
  initial begin
    o_addr = 5'h1F;
    o_wdata = 32'hFFFF_FFFF;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // one-cycle write strobe beside address and data, never stalled
  task automatic write_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // one-cycle read strobe; data stands only in the following cycle
  task automatic read_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask
endmodule

/* ser_status_tb_top.sv */
`timescale 1ns/100ps
// self-checking bench for the status and event reporting block
module ser_status_tb_top import ser_pkg::*; ;
  localparam logic [31:0] ID_WORD = 32'h0000_C0DE;  // identity word, arbitrary value
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_busy = 1'b0;               // pending operations
  logic [7:0] i_std_evt = 8'h00;     // event pulses
  logic [15:0] i_oper_cond = 16'h0000;
  logic [15:0] i_ques_cond = 16'h0000;
  logic i_err_push = 1'b0;
  logic [7:0] i_err_code = 8'h00;
  logic [31:0] i_reading = 32'h0000_0000;
  logic [4:0] i_addr;
  logic [31:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [31:0] o_rdata;
  logic [7:0] o_status_byte;
  logic [1:0] o_function;
  logic o_auto_range;
  int fail_count = 0;
  int n_checks = 0;
  // reading stimulus and the expected compare result
  logic [31:0] rdg [3] = '{32'h0000_0005, 32'h0000_000F, 32'h0000_0019};
  logic [1:0] fexp [3] = '{SER_LOW, SER_PASS, SER_HIGH};

  // 125 MHz clock
  always #4 i_core_clk = ~i_core_clk;

  ser_host i_ser_host (.i_core_clk(i_core_clk), .i_rdata(o_rdata), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

  ser_status #(.IDENT(ID_WORD)) i_ser_status (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_busy(i_busy),
    .i_std_evt(i_std_evt), .i_oper_cond(i_oper_cond), .i_ques_cond(i_ques_cond),
    .i_err_push(i_err_push), .i_err_code(i_err_code), .i_reading(i_reading),
    .o_rdata(o_rdata), .o_status_byte(o_status_byte), .o_function(o_function),
    .o_auto_range(o_auto_range));

  // counts one comparison and reports a mismatch at once
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // status byte pins compared against an expected byte
  task automatic chk_stb(input string what, input logic [7:0] exp);
    chk(what, {24'h0, exp}, {24'h0, o_status_byte});
  endtask
  // register read compared against an expected value
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    i_ser_host.read_reg(a, d);
    chk(what, exp, d);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_ser_host.write_reg(a, d);
  endtask
  task automatic cmd(input logic [7:0] c);
    i_ser_host.write_reg(SER_A_CMD, {24'h0, c});
  endtask
  // lets n edges pass, then steps off the edge
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // one-cycle standard event pulse
  task automatic pulse(input logic [7:0] v);
    @(posedge i_core_clk);
    i_std_evt <= v;
    @(posedge i_core_clk);
    i_std_evt <= 8'h00;
  endtask
  // prints the counts and the verdict, then ends the run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fail_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    rd_chk(SER_A_ESE, 32'h0, "mask after reset");
    rd_chk(SER_A_STB, 32'h0, "status after reset");
    rd_chk(SER_A_IDN, ID_WORD, "identity");
    rd_chk(5'h1F, 32'h0, "unmapped read");
    // event mask and summary bit
    wr(SER_A_ESE, 32'h0000_00FF);
    rd_chk(SER_A_ESE, 32'h0000_00FF, "mask top value");
    wr(SER_A_ESE, 32'h0000_0020);
    wr(5'h1F, 32'h0000_00FF);
    rd_chk(SER_A_ESE, 32'h0000_0020, "mask");
    pulse(8'h40);
    wait_n(3);
    chk_stb("summary masked off", 8'h00);
    pulse(8'h20);
    wait_n(5);
    chk_stb("summary set", 8'h20);
    rd_chk(SER_A_STB, 32'h0000_0020, "status read");
    rd_chk(SER_A_ESR, 32'h0000_0060, "flags held");
    rd_chk(SER_A_ESR, 32'h0, "flags cleared by read");
    wait_n(1);
    chk_stb("summary cleared", 8'h00);
    wr(SER_A_SRE, 32'h0000_00FF);
    rd_chk(SER_A_SRE, 32'h0000_00BF, "service mask");
    wr(SER_A_SRE, 32'h0);
    // completion command and query
    i_busy <= 1'b1;
    cmd(SER_C_OPC);
    wait_n(4);
    rd_chk(SER_A_ESR, 32'h0, "no completion while busy");
    i_busy <= 1'b0;
    wait_n(3);
    rd_chk(SER_A_ESR, 32'h0000_0001, "completion flag");
    i_busy <= 1'b1;
    cmd(SER_C_OPCQ);
    wait_n(3);
    rd_chk(SER_A_OUTQ, 32'h0, "no answer while busy");
    cmd(SER_C_WAI);
    rd_chk(SER_A_ESE, 32'h0000_0020, "in-order after wait");
    i_busy <= 1'b0;
    wait_n(3);
    chk_stb("message waiting", 8'h10);
    rd_chk(SER_A_ESR, 32'h0, "query leaves flag");
    rd_chk(SER_A_OUTQ, {24'h0, SER_ASCII_1}, "ascii one");
    rd_chk(SER_A_OUTQ, 32'h0, "queue emptied");
    // operation and questionable groups
    @(posedge i_core_clk);
    i_oper_cond <= 16'h0005;
    i_ques_cond <= 16'h8001;
    wait_n(3);
    rd_chk(SER_A_OPC, 32'h0000_0005, "oper condition");
    rd_chk(SER_A_OPE, 32'h0000_0005, "oper event");
    rd_chk(SER_A_OPE, 32'h0000_0005, "oper event kept");
    rd_chk(SER_A_QUE, 32'h0000_8001, "ques event");
    rd_chk(SER_A_QUC, 32'h0000_8001, "ques condition");
    wr(SER_A_OPM, 32'h0000_0004);
    rd_chk(SER_A_OPM, 32'h0000_0004, "oper mask");
    wr(SER_A_QUM, 32'h0000_8000);
    rd_chk(SER_A_QUM, 32'h0000_8000, "ques mask");
    wait_n(1);
    chk_stb("group summaries", 8'h88);
    wr(SER_A_SRE, 32'h0000_0080);
    wait_n(1);
    chk_stb("request bit", 8'hC8);
    wr(SER_A_SRE, 32'h0);
    cmd(SER_C_PRES);
    rd_chk(SER_A_OPM, 32'h0, "preset oper mask");
    rd_chk(SER_A_QUM, 32'h0, "preset ques mask");
    rd_chk(SER_A_OPE, 32'h0, "preset oper event");
    rd_chk(SER_A_QUE, 32'h0, "preset ques event");
    // clear-status with events, flags and output queue holding something
    cmd(SER_C_OPCQ);
    @(posedge i_core_clk);
    i_oper_cond <= 16'h0007;
    i_ques_cond <= 16'h8003;
    pulse(8'h04);
    wait_n(3);
    cmd(SER_C_CLS);
    rd_chk(SER_A_OPE, 32'h0, "clear oper event");
    rd_chk(SER_A_QUE, 32'h0, "clear ques event");
    rd_chk(SER_A_ESR, 32'h0, "clear flags");
    rd_chk(SER_A_OUTQ, 32'h0, "clear out queue");
    // error queue order
    @(posedge i_core_clk);
    i_err_push <= 1'b1;
    i_err_code <= 8'h11;
    @(posedge i_core_clk);
    i_err_code <= 8'h22;
    @(posedge i_core_clk);
    i_err_push <= 1'b0;
    wait_n(2);
    chk_stb("error waiting", 8'h04);
    rd_chk(SER_A_ERRQ, 32'h0000_0011, "oldest error");
    rd_chk(SER_A_ERRQ, 32'h0000_0022, "next error");
    rd_chk(SER_A_ERRQ, 32'h0, "error queue empty");
    // mode flags, limits and compare result
    for (int i = 0; i < 3; i++) begin
      wr(SER_A_MODE, 32'h1 << i);
      rd_chk(SER_A_MODE, 32'h1 << i, "mode flag");
    end
    wr(SER_A_LOW, 32'h0000_000A);
    wr(SER_A_UPP, 32'h0000_0014);
    wr(SER_A_NOM, 32'h0000_000F);
    wr(SER_A_REF, 32'h0000_ABCD);
    rd_chk(SER_A_NOM, 32'h0000_000F, "nominal");
    rd_chk(SER_A_REF, 32'h0000_ABCD, "reference");
    for (int i = 0; i < 3; i++) begin
      i_reading <= rdg[i];
      wait_n(3);
      rd_chk(SER_A_FAIL, {30'h0, fexp[i]}, "compare result");
    end
    // save, reset, recall
    wr(SER_A_MODE, 32'h0000_0007);
    wr(SER_A_SLOT, 32'h0000_0003);
    rd_chk(SER_A_SLOT, 32'h0000_0003, "slot index");
    cmd(SER_C_SAV);
    wr(SER_A_LOW, 32'h0000_0063);
    cmd(SER_C_RST);
    wait_n(2);
    chk("auto range", 32'h1, {31'h0, o_auto_range});
    chk("function", 32'h0, {30'h0, o_function});
    rd_chk(SER_A_MODE, 32'h0000_0008, "mode after reset");
    rd_chk(SER_A_LOW, 32'h0000_0063, "limit kept");
    wr(SER_A_SLOT, 32'h0000_0003);
    cmd(SER_C_RCL);
    rd_chk(SER_A_MODE, 32'h0000_0007, "recalled mode");
    rd_chk(SER_A_LOW, 32'h0000_000A, "recalled low");
    rd_chk(SER_A_UPP, 32'h0000_0014, "recalled upper");
    chk("auto off", 32'h0, {31'h0, o_auto_range});
    print_verdict();
  end
endmodule
